// *** shift4_reg.sv ***
// four-stage parallel-access shift register with left/right clocks and output fifo
`timescale 1ns/1ps
`include "shift4_consts.svh"
module shift4_reg (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // register controls, sampled on mclk
  input  wire logic                 mode_ctl,
  input  wire logic                 right_clk,
  input  wire logic                 left_clk,
  input  wire logic                 serial_in,
  input  wire shift4_pkg::stage_vec_t par_in,
  // parallel outputs
  output logic                      first_stage_out,
  output logic                      second_stage_out,
  output logic                      third_stage_out,
  output logic                      last_stage_out,
  // stream of words captured after each load or shift
  output logic                      word_valid,
  input  wire logic                 word_ready,
  output shift4_pkg::stage_vec_t    word_data,
  // high one cycle after the fifo is full; further updates are stalled while it is full
  output logic                      stall
);
  // ==========================================================
  // edge detection on the external clocks
  // ==========================================================
  logic right_d_r, right_d_nxt, left_d_r, left_d_nxt;
  logic right_fall, left_fall;

  function automatic logic falling(input logic prev, input logic now);
    falling = prev && !now;
  endfunction : falling

  // a falling edge that lands while full is lost; the stall output tells the source
  assign right_fall = falling(right_d_r, right_clk);
  assign left_fall  = falling(left_d_r, left_clk);

  always_comb begin
    right_d_nxt = right_clk;
    left_d_nxt  = left_clk;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      right_d_r <= 1'b0;
      left_d_r  <= 1'b0;
    end else begin
      right_d_r <= right_d_nxt;
      left_d_r  <= left_d_nxt;
    end
  end

  // ==========================================================
  // stage storage
  // ==========================================================
  typedef enum logic [2:0] {
    OP_HOLD  = 3'b001,
    OP_LOAD  = 3'b010,
    OP_RIGHT = 3'b100
  } op_t;

  op_t                    op;
  shift4_pkg::stage_vec_t stage_r, stage_nxt;
  logic                   fifo_in_ready;

  // only the clock that mode selects can act; mode changes alone never do
  always_comb begin
    op = OP_HOLD;
    if (fifo_in_ready) begin
      if (mode_ctl == `MODE_LOAD && left_fall) begin
        op = OP_LOAD;
      end else if (mode_ctl == `MODE_RIGHT && right_fall) begin
        op = OP_RIGHT;
      end
    end
  end

  // next value of one stage from its own parallel input or its upstream neighbour
  function automatic logic stage_next(input op_t sel, input logic cur, input logic par, input logic upstream);
    case (sel)
      OP_LOAD:  stage_next = par;
      OP_RIGHT: stage_next = upstream;
      default:  stage_next = cur;
    endcase
  endfunction : stage_next

  // bit 0 is the first stage, bit 3 the last; serial only enters the first stage
  always_comb begin
    stage_nxt[0] = stage_next(op, stage_r[0], par_in[0], serial_in);
    stage_nxt[1] = stage_next(op, stage_r[1], par_in[1], stage_r[0]);
    stage_nxt[2] = stage_next(op, stage_r[2], par_in[2], stage_r[1]);
    stage_nxt[3] = stage_next(op, stage_r[3], par_in[3], stage_r[2]);
  end

  // no reset on the stages: contents stay undefined until the first load or four shifts
  always_ff @(posedge mclk) begin
    stage_r <= stage_nxt;
  end

  // outputs mirror the stages every cycle, no enable
  assign first_stage_out  = stage_r[0];
  assign second_stage_out = stage_r[1];
  assign third_stage_out  = stage_r[2];
  assign last_stage_out   = stage_r[3];

  // ==========================================================
  // output word buffer
  // ==========================================================
  logic push_r;
  logic push_nxt;
  logic stall_r;
  logic stall_nxt;
  logic fifo_ready_raw;

  // stall shows a full fifo; the one-cycle gap after each taken edge is not reported
  always_comb begin
    push_nxt  = (op != OP_HOLD);
    stall_nxt = !fifo_ready_raw;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      push_r  <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      push_r  <= push_nxt;
      stall_r <= stall_nxt;
    end
  end

  assign stall = stall_r;

  // one update is in flight at most, as no edge is taken while push_r is high, so ready is checked a cycle early with no slot spare
  assign fifo_in_ready = fifo_ready_raw && !push_r;

  // the fifo head passes one more register so the ports come straight from flops;
  // the block therefore holds nine words before it stalls
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  shift4_pkg::stage_vec_t fifo_out_data;

  word_fifo #(
    .WIDTH (`STAGES),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (push_r),
    .in_ready  (fifo_ready_raw),
    .in_data   (stage_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // output word register
  // ==========================================================
  logic                   word_valid_r;
  logic                   word_valid_nxt;
  shift4_pkg::stage_vec_t word_data_r;
  shift4_pkg::stage_vec_t word_data_nxt;

  // the head moves up in the same cycle the old word leaves, so a steady drain loses no cycle
  always_comb begin
    fifo_out_ready = !word_valid_r || word_ready;
    word_valid_nxt = word_valid_r && !word_ready;
    word_data_nxt  = word_data_r;
    if (fifo_out_valid && fifo_out_ready) begin
      word_valid_nxt = 1'b1;
      word_data_nxt  = fifo_out_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      word_valid_r <= 1'b0;
      word_data_r  <= `WORD_RESET;
    end else begin
      word_valid_r <= word_valid_nxt;
      word_data_r  <= word_data_nxt;
    end
  end

  assign word_valid = word_valid_r;
  assign word_data  = word_data_r;
endmodule : shift4_reg

// *** shift4_consts.svh ***
// constants for the four-stage bidirectional shift register
// What this block does
// - four stages, each with its own parallel input and output, plus one serial input.
// - two operations only: parallel load and shift toward the last stage; a shift toward the first stage is a load of fed-back stages.
// - with mode high, a falling edge of the left/load clock loads all four parallel inputs; an edge is dropped while the fifo is full.
// - during a parallel load the serial input is ignored.
// - with mode low, a falling edge of the right clock moves serial into stage one and each stage into the next; an edge is dropped while the fifo is full.
// - the right clock does nothing with mode high, the left/load clock nothing with mode low.
// - with the selected clock steady the stages hold their values.
// - the listed mode changes with steady clocks leave the stages unchanged.
`ifndef SHIFT4_CONSTS_SVH
`define SHIFT4_CONSTS_SVH
`define STAGES      4
`define FIFO_DEPTH  8
`define FIFO_AW     3
`define MODE_LOAD   1'b1
`define MODE_RIGHT  1'b0
`define WORD_RESET  4'h0
`endif

// *** shift4_pkg.sv ***
// types for the four-stage bidirectional shift register
package shift4_pkg;
  typedef logic [3:0] stage_vec_t;
endpackage : shift4_pkg

// *** word_fifo.sv ***
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];

  always_comb begin
    wr_nxt  = push ? wr_r + 1'b1 : wr_r;
    rd_nxt  = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage itself needs no reset; only written words are ever read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule : word_fifo

// *** shift4_reg_assertions.sv ***
// port checker for the four-stage shift register
`timescale 1ns/1ps
module shift4_reg_assertions (
  // controls and data in
  input wire logic                   mclk, reset, mode_ctl, right_clk, left_clk, serial_in,
  input wire shift4_pkg::stage_vec_t par_in,
  // outputs, with the word_ready input
  input wire logic                   first_stage_out, second_stage_out, third_stage_out, last_stage_out,
  input wire logic                   word_valid, word_ready, stall,
  input wire shift4_pkg::stage_vec_t word_data
);
  // ====
  // stage and word checks
  wire shift4_pkg::stage_vec_t q = {last_stage_out, third_stage_out, second_stage_out, first_stage_out};
  // no waiting word and no stall means the edge is taken, unless it lands in the cycle after a taken edge
  wire logic                   idle = !word_valid && !stall;
  // stages are unknown until the first load, so the stability checks wait for it
  logic                        primed_r = 1'b0;
  always @(posedge mclk) begin
    if (!reset && mode_ctl && $fell(left_clk) && idle) begin
      primed_r <= 1'b1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_load; mode_ctl && $fell(left_clk) && idle |=> q == $past(par_in); endproperty
  a_load: assert property (p_load) else $error("load missed");
  property p_right; primed_r && !mode_ctl && $fell(right_clk) && idle |=> q == {$past(q[2:0]), $past(serial_in)};
  endproperty
  a_right: assert property (p_right) else $error("shift missed");
  property p_word; mode_ctl && $fell(left_clk) && idle |-> ##[2:4] word_valid; endproperty
  a_word: assert property (p_word) else $error("no word");
  property p_hold; primed_r && !$fell(left_clk) && !$fell(right_clk) |=> $stable(q); endproperty
  a_hold: assert property (p_hold) else $error("stage drift");
  property p_rign; primed_r && mode_ctl && $fell(right_clk) && !$fell(left_clk) |=> $stable(q); endproperty
  a_rign: assert property (p_rign) else $error("right acted");
  property p_lign; primed_r && !mode_ctl && $fell(left_clk) && !$fell(right_clk) |=> $stable(q); endproperty
  a_lign: assert property (p_lign) else $error("left acted");
  property p_mode; primed_r && $changed(mode_ctl) && !$fell(left_clk) && !$fell(right_clk) |=> $stable(q);
  endproperty
  a_mode: assert property (p_mode) else $error("mode change hit");
  property p_keep; word_valid && !word_ready |=> word_valid && $stable(word_data); endproperty
  a_keep: assert property (p_keep) else $error("word lost");
endmodule : shift4_reg_assertions
bind shift4_reg shift4_reg_assertions chk (.mclk, .reset, .mode_ctl, .right_clk, .left_clk, .serial_in,
  .par_in, .first_stage_out, .second_stage_out, .third_stage_out, .last_stage_out, .word_valid,
  .word_ready, .stall, .word_data);

// *** shift4_driver.sv ***
// model of the surrounding logic: mode, clocks and data
`timescale 1ns/1ps
module shift4_driver (
  // clock and stage feedback
  input  wire logic                   mclk,
  input  wire shift4_pkg::stage_vec_t q,
  // register controls
  output logic                        mode_ctl,
  output logic                        right_clk,
  output logic                        left_clk,
  output logic                        serial_in,
  output shift4_pkg::stage_vec_t      par_in
);
  // ====
  // one operation: c picks {left, right} clocks
  initial {mode_ctl, right_clk, left_clk, serial_in, par_in} = 8'h00;
  task automatic op(input logic m, input logic s, input logic [3:0] p, input logic lft, input logic [1:0] c);
    @(posedge mclk) #2 mode_ctl = m; // mode moves only with both clocks low
    serial_in = s;
    par_in = lft ? {p[3], q[3:1]} : p; // stages fed back for a left shift
    @(posedge mclk) #2 {left_clk, right_clk} = c; // one source may feed both
    @(posedge mclk) #2 {left_clk, right_clk} = 2'b00;
    repeat (3) @(posedge mclk);
  endtask : op
endmodule : shift4_driver

// *** bidir_parallel_shift_reg4_tb.sv ***
// testbench for the four-stage shift register
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("unexpected at %0t: mismatch", $time); end end
module bidir_parallel_shift_reg4_tb;
  logic                   mclk, reset, word_ready, seen_stall, word_valid, stall;
  logic                   mode_ctl, right_clk, left_clk, serial_in;
  shift4_pkg::stage_vec_t par_in, word_data;
  wire [3:0]              q;
  int                     bad_count, total_checks, pops;
  shift4_driver drv (.mclk, .q, .mode_ctl, .right_clk, .left_clk, .serial_in, .par_in);
  shift4_reg uut (.mclk, .reset, .mode_ctl, .right_clk, .left_clk, .serial_in, .par_in,
    .first_stage_out(q[0]), .second_stage_out(q[1]), .third_stage_out(q[2]), .last_stage_out(q[3]),
    .word_valid, .word_ready, .word_data, .stall);
  // ====
  // clock, monitors, watchdog
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (reset) begin
      seen_stall <= 1'b0;
      pops       <= 0;
    end else begin
      if (stall === 1'b1) seen_stall <= 1'b1;
      if (word_valid === 1'b1 && word_ready === 1'b1) pops <= pops + 1;
    end
  end
  initial begin
    #20us;
    bad_count++;
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // ====
  // scenarios
  task automatic t_load_right;
    drv.op(1'b1, 1'b1, 4'h9, 1'b0, 2'b11);
    `CHK(q, 4'h9)
    drv.op(1'b0, 1'b0, 4'h0, 1'b0, 2'b01);
    `CHK(q, 4'h2)
    drv.op(1'b0, 1'b1, 4'hF, 1'b0, 2'b11);
    `CHK(q, 4'h5)
  endtask : t_load_right
  task automatic t_ignore_left;
    drv.op(1'b1, 1'b0, 4'h0, 1'b0, 2'b01);
    `CHK(q, 4'h5)
    drv.op(1'b0, 1'b0, 4'h0, 1'b0, 2'b10);
    `CHK(q, 4'h5)
    drv.op(1'b1, 1'b0, 4'h8, 1'b1, 2'b10);
    `CHK(q, 4'hA)
  endtask : t_ignore_left
  task automatic t_fifo;
    int base;
    repeat (2) @(posedge mclk);
    #2 word_ready = 1'b0;
    base = pops;
    for (int i = 1; i <= 9; i++) drv.op(1'b1, 1'b0, 4'(i), 1'b0, 2'b10);
    @(posedge mclk);
    #2 `CHK(stall, 1'b1)
    `CHK(word_data, 4'h1)
    word_ready = 1'b1;
    repeat (12) @(posedge mclk);
    #2 `CHK(pops - base, 9)
    `CHK(word_valid, 1'b0)
    `CHK(seen_stall, 1'b1)
    `CHK(stall, 1'b0)
  endtask : t_fifo
  task automatic t_reset_mid;
    @(posedge mclk);
    #2 word_ready = 1'b0;
    drv.op(1'b1, 1'b0, 4'h3, 1'b0, 2'b10);
    @(posedge mclk);
    #2 `CHK(word_valid, 1'b1)
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    #2 reset = 1'b0;
    `CHK(word_valid, 1'b0)
    `CHK(q, 4'h3)
    word_ready = 1'b1;
  endtask : t_reset_mid
  initial begin
    bad_count = 0;
    total_checks = 0;
    word_ready = 1'b1;
    reset = 1'b1;
    repeat (20) @(posedge mclk);
    #2 reset = 1'b0;
    t_load_right();
    t_ignore_left();
    t_fifo();
    t_reset_mid();
    tally_and_finish();
  end
endmodule : bidir_parallel_shift_reg4_tb
